// ===== rtc_consts.svh
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// Fixed bus address of the slave.
`define RTC_SLAVE_ADDR 7'h4c

// Register indices; a Wishbone byte address is four times the index.
`define RTC_IDX_LOCAL 8'h00
`define RTC_IDX_RMT_MSB 8'h01
`define RTC_IDX_STATUS 8'h02
`define RTC_IDX_CONFIG 8'h03
`define RTC_IDX_LHS 8'h05
`define RTC_IDX_RHS_MSB 8'h07
`define RTC_IDX_RMT_LSB 8'h10
`define RTC_IDX_RHS_LSB 8'h13
`define RTC_IDX_CRIT_SP 8'h19
`define RTC_IDX_CRIT_HYST 8'h21
`define RTC_IDX_ENH_CFG 8'h45
`define RTC_IDX_NONE 8'hff

// Field positions.
`define RTC_CFG_ALERT_MASK 7
`define RTC_CFG_CRIT_UNLOCK 1
`define RTC_ENH_USF 3
`define RTC_ENH_FILTER 0
`define RTC_ST_LHIGH 6
`define RTC_ST_RHIGH 4
`define RTC_ST_DIODE 2
`define RTC_ST_CRIT 1

// Reset values.
`define RTC_RST_CONFIG 8'h00
`define RTC_RST_ENH 8'h00
`define RTC_RST_LHS 8'h46
`define RTC_RST_RHS_MSB 8'h55
`define RTC_RST_CRIT_SP 8'h6e
`define RTC_RST_CRIT_HYST 8'h0a

// Forced readings in 1/256 degree steps; saturation limits in 1/32 degree steps.
`define RTC_FORCE_GND_S 16'h8000
`define RTC_FORCE_GND_U 16'h0000
`define RTC_FORCE_OPEN_S 16'h7f00
`define RTC_FORCE_OPEN_U 16'hff00
`define RTC_SAT_S_MAX 14'h0fff
`define RTC_SAT_S_MIN 14'h3000

// Bus stuck-low timeout.
`define RTC_TIMEOUT_MS 35
`define RTC_CLK_KHZ 250000
`define RTC_TIMEOUT_CYC (`RTC_TIMEOUT_MS * `RTC_CLK_KHZ)

`endif

// ===== rtc_pkg.sv
package rtc_pkg;
	typedef enum logic [2:0] {
		SM_IDLE = 3'b000,
		SM_ADDR = 3'b001,
		SM_CMD = 3'b010,
		SM_WDATA = 3'b011,
		SM_RDATA = 3'b100,
		SM_IGNORE = 3'b101
	} rtc_smb_state_e;
	typedef logic [7:0] rtc_byte_t;
endpackage

// ===== rtc_temp_if.sv
`timescale 1ns/1ns
interface rtc_temp_if;
	logic [13:0] raw;
	logic convDone;
	logic shortGnd;
	logic openFault;
	logic unsigned_format_sel;
	logic filterEn;
	logic [7:0] critSp;
	logic [7:0] critHyst;
	logic [15:0] word;
	logic critFlag;
	logic faultFlag;
	modport ctl (output raw, convDone, shortGnd, openFault, unsigned_format_sel, filterEn, critSp, critHyst,
		input word, critFlag, faultFlag);
	modport fmt (input raw, convDone, shortGnd, openFault, unsigned_format_sel, filterEn, critSp, critHyst,
		output word, critFlag, faultFlag);
endinterface

// ===== rtc_sync2.sv
`timescale 1ns/1ns
module rtc_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstN,
	// Levels in and synchronised copies out
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] stage1;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			stage1 <= '0;
			syncOut <= '0;
		end else begin
			stage1 <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule

// ===== rtc_crit_fmt.sv
`timescale 1ns/1ns
`include "rtc_consts.svh"
module rtc_crit_fmt (
	// Clock and reset
	input wire logic clk,
	input wire logic rstN,
	// Raw reading in, formatted word and flags out
	rtc_temp_if.fmt tf
);
	logic signed [13:0] sat;
	logic [15:0] next_word;
	logic signed [9:0] rInt;
	logic signed [9:0] spInt;
	logic signed [9:0] thr;

	always_comb begin
		sat = $signed(tf.raw);
		if (tf.unsigned_format_sel) begin
			if (sat < 0) begin
				sat = '0;
			end
		end else if (sat > $signed(`RTC_SAT_S_MAX)) begin
			sat = $signed(`RTC_SAT_S_MAX);
		end else if (sat < $signed(`RTC_SAT_S_MIN)) begin
			sat = $signed(`RTC_SAT_S_MIN);
		end
		if (!tf.filterEn) begin
			sat[1:0] = 2'h0;
		end
		next_word = {sat[12:0], 3'h0};
		if (tf.shortGnd) begin
			next_word = tf.unsigned_format_sel ? `RTC_FORCE_GND_U : `RTC_FORCE_GND_S;
		end else if (tf.openFault) begin
			next_word = tf.unsigned_format_sel ? `RTC_FORCE_OPEN_U : `RTC_FORCE_OPEN_S;
		end
	end

	assign rInt = tf.unsigned_format_sel ? $signed({2'h0, next_word[15:8]})
		: $signed({{2{next_word[15]}}, next_word[15:8]});
	assign spInt = tf.unsigned_format_sel ? $signed({2'h0, tf.critSp}) : $signed({{2{tf.critSp[7]}}, tf.critSp});
	assign thr = spInt - $signed({2'h0, tf.critHyst});

	// The forced fault readings go through the same compare as real ones.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			tf.word <= 16'h0000;
			tf.critFlag <= 1'b0;
			tf.faultFlag <= 1'b0;
		end else if (tf.convDone) begin
			tf.word <= next_word;
			tf.faultFlag <= tf.openFault;
			if (rInt > spInt) begin
				tf.critFlag <= 1'b1;
			end else if (rInt <= thr) begin
				tf.critFlag <= 1'b0;
			end
		end
	end

	a_crit_set_above: assert property (@(posedge clk) disable iff (!rstN)
		tf.convDone && rInt > spInt |=> tf.critFlag)
		else $error("Crit flag not set above setpoint.");
	a_crit_hyst_hold: assert property (@(posedge clk) disable iff (!rstN)
		tf.convDone && tf.critFlag && rInt > thr |=> tf.critFlag)
		else $error("Crit flag cleared inside hysteresis band.");
	a_force_ground: assert property (@(posedge clk) disable iff (!rstN)
		tf.convDone && tf.shortGnd |=> tf.word == (tf.unsigned_format_sel ? 16'h0000 : 16'h8000))
		else $error("Grounded diode reading not forced.");
	a_force_open: assert property (@(posedge clk) disable iff (!rstN)
		tf.convDone && !tf.shortGnd && tf.openFault
		|=> tf.word == (tf.unsigned_format_sel ? 16'hff00 : 16'h7f00))
		else $error("Open diode reading not forced.");
	a_low_bits_zero: assert property (@(posedge clk) disable iff (!rstN)
		tf.convDone && !tf.filterEn |=> tf.word[4:0] == 5'h00)
		else $error("Unused low bits of remote word not zero.");
endmodule

// ===== rtc_sensor_top.sv
`timescale 1ns/1ns
`include "rtc_consts.svh"
// Contract
// - Critical output pulled low while the critical flag is set.
// - Critical flag sets when remote reading exceeds the critical setpoint.
// - Critical flag clears at or below setpoint minus hysteresis.
// - Critical compare uses whole degrees, fraction ignored.
// - Critical setpoint locked after reset until the unlock bit is set.
// - Setpoint signed or unsigned per format select; span +255 to -128.
// - Slave only: clock is input, never stretched; data line two-way.
// - Answers only the fixed address 1001100.
// - Temperatures are left-justified 16-bit words; unused low bits zero. Local temperature is kept as a single byte, localT.
// - Temperatures saturate at format limits, never wrap.
// - Remote values are 11-bit, eighth-degree steps, signed or unsigned.
// - With filter on, remote reading widens to 13 bits, 1/32 degree.
// - Local temperature and critical setpoint are signed whole-degree bytes.
// - Unsigned format makes the critical setpoint an unsigned byte.
// - Grounded diode forces reading to -128 signed or 0 unsigned.
// - Open or supply-shorted diode forces +127 signed or +255 unsigned.
// - Open diode sets fault flag, which drives neither output.
// - Forced readings feed every remote compare and may raise outputs.
// - Every byte is shifted most significant bit first.
// - After a read byte, acknowledge or no-acknowledge both accepted.
// - With mask clear, alert low for any status bit but fault.
// - Bus engine returns idle when a line stays low past the timeout.
module rtc_sensor_top #(
	parameter int TIMEOUT_CYC = `RTC_TIMEOUT_CYC,
	parameter logic [7:0] CRIT_SP_RST = `RTC_RST_CRIT_SP
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Two-wire bus pins
	input wire logic smbClk,
	input wire logic smbDatIn,
	output logic smbDatOut,
	output logic smbDatOe,
	// Measurement front end
	input wire logic [13:0] remoteRaw,
	input wire logic [7:0] localRaw,
	input wire logic convDone,
	input wire logic diodeShortGnd,
	input wire logic diodeOpen,
	// Open-drain outputs
	input wire logic critOutNIn,
	output logic critOutN,
	output logic critOutNOe,
	input wire logic alertOutNIn,
	output logic alertOutN,
	output logic alertOutNOe
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);

	logic rstMeta;
	logic rstN;
	logic [1:0] busS;
	logic [1:0] faultS;
	logic sclS;
	logic sdaS;
	logic sclD;
	logic sdaD;
	logic sclRise;
	logic sclFall;
	logic startC;
	logic stopC;
	logic timedOut;
	rtc_pkg::rtc_smb_state_e state;
	logic [3:0] bitCnt;
	logic [7:0] shiftIn;
	logic [7:0] rdShift;
	logic [7:0] ptr;
	logic rw;
	logic mAck;
	logic smbWr;
	logic [7:0] smbWdata;
	logic rdLoad;
	logic [7:0] rdByte;
	logic rdMsb;
	logic [7:0] cfg;
	logic [7:0] enh;
	logic [7:0] lhs;
	logic [7:0] rhsMsb;
	logic [2:0] rhsLsb;
	logic [7:0] critSp;
	logic [7:0] critHyst;
	logic [7:0] localT;
	logic lhigh;
	logic rhigh;
	logic convD;
	logic rhighHit;
	logic statRd;
	logic [7:0] statusByte;
	logic [7:0] adrIdx;
	logic wbTake;
	logic wrEn;
	logic [7:0] wrIdx;
	logic [7:0] wrData;

	// The reset is released through two flops so every flop leaves reset together.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	rtc_sync2 #(.W(2)) uBusSync (
		.clk(clk),
		.rstN(rstN),
		.asyncIn({smbClk, smbDatIn}),
		.syncOut(busS)
	);

	rtc_sync2 #(.W(2)) uFaultSync (
		.clk(clk),
		.rstN(rstN),
		.asyncIn({diodeShortGnd, diodeOpen}),
		.syncOut(faultS)
	);

	rtc_temp_if tf();

	assign tf.raw = remoteRaw;
	assign tf.convDone = convDone;
	assign tf.shortGnd = faultS[1];
	assign tf.openFault = faultS[0];
	assign tf.unsigned_format_sel = enh[`RTC_ENH_USF];
	assign tf.filterEn = enh[`RTC_ENH_FILTER];
	assign tf.critSp = critSp;
	assign tf.critHyst = critHyst;

	rtc_crit_fmt uCrit (
		.clk(clk),
		.rstN(rstN),
		.tf(tf.fmt)
	);

	always_comb begin
		statusByte = 8'h00;
		statusByte[`RTC_ST_LHIGH] = lhigh;
		statusByte[`RTC_ST_RHIGH] = rhigh;
		statusByte[`RTC_ST_DIODE] = tf.faultFlag;
		statusByte[`RTC_ST_CRIT] = tf.critFlag;
	end

	// Shared by the Wishbone port and the two-wire read path.
	function automatic rtc_pkg::rtc_byte_t regRead(input rtc_pkg::rtc_byte_t idx);
		case (idx)
			`RTC_IDX_LOCAL: regRead = localT;
			`RTC_IDX_RMT_MSB: regRead = tf.word[15:8];
			`RTC_IDX_RMT_LSB: regRead = tf.word[7:0];
			`RTC_IDX_STATUS: regRead = statusByte;
			`RTC_IDX_CONFIG: regRead = cfg;
			`RTC_IDX_LHS: regRead = lhs;
			`RTC_IDX_RHS_MSB: regRead = rhsMsb;
			`RTC_IDX_RHS_LSB: regRead = {rhsLsb, 5'h00};
			`RTC_IDX_CRIT_SP: regRead = critSp;
			`RTC_IDX_CRIT_HYST: regRead = critHyst;
			`RTC_IDX_ENH_CFG: regRead = enh;
			default: regRead = 8'h00;
		endcase
	endfunction

	assign sclS = busS[1];
	assign sdaS = busS[0];
	assign sclRise = sclS & ~sclD;
	assign sclFall = ~sclS & sclD;
	assign startC = sclS & sclD & sdaD & ~sdaS;
	assign stopC = sclS & sclD & ~sdaD & sdaS;
	// A process, not an assign, so a register change behind an unchanged pointer is seen.
	always_comb begin
		rdByte = regRead(ptr);
	end
	assign rdMsb = rdByte[7];
	assign smbDatOut = 1'b0;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			sclD <= 1'b0;
			sdaD <= 1'b0;
		end else begin
			sclD <= sclS;
			sdaD <= sdaS;
		end
	end

	// stuck-low timers
	// Each line has its own timer, so normal traffic on the other line cannot mask a stuck one.
	for (genvar gi = 0; gi < 2; gi++) begin : gLow
		logic [TW-1:0] lowCnt;
		logic stuck;
		assign stuck = lowCnt == TW'(TIMEOUT_CYC - 1);
		always_ff @(posedge clk or negedge rstN) begin
			if (!rstN) begin
				lowCnt <= '0;
			end else if (busS[gi]) begin
				lowCnt <= '0;
			end else if (!stuck) begin
				lowCnt <= lowCnt + TW'(1);
			end
		end
	end
	assign timedOut = gLow[0].stuck | gLow[1].stuck;

	// The slave never holds the clock low, so a byte may not wait on register access.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state <= rtc_pkg::SM_IDLE;
			bitCnt <= 4'h0;
			shiftIn <= 8'h00;
			rdShift <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			mAck <= 1'b0;
			smbDatOe <= 1'b0;
			smbWr <= 1'b0;
			smbWdata <= 8'h00;
			rdLoad <= 1'b0;
		end else begin
			smbWr <= 1'b0;
			rdLoad <= 1'b0;
			if (timedOut || stopC) begin
				state <= rtc_pkg::SM_IDLE;
				bitCnt <= 4'h0;
				smbDatOe <= 1'b0;
			end else if (startC) begin
				state <= rtc_pkg::SM_ADDR;
				bitCnt <= 4'h0;
				smbDatOe <= 1'b0;
			end else if (sclRise && state != rtc_pkg::SM_IDLE) begin
				if (bitCnt < 4'h8) begin
					shiftIn <= {shiftIn[6:0], sdaS};
					bitCnt <= bitCnt + 4'h1;
				end else if (bitCnt == 4'h8) begin
					mAck <= ~sdaS;
					bitCnt <= 4'h9;
				end
			end else if (sclFall && state != rtc_pkg::SM_IDLE) begin
				if (bitCnt == 4'h8) begin
					case (state)
						rtc_pkg::SM_ADDR: begin
							if (shiftIn[7:1] == `RTC_SLAVE_ADDR) begin
								smbDatOe <= 1'b1;
								rw <= shiftIn[0];
							end else begin
								state <= rtc_pkg::SM_IGNORE;
							end
						end
						rtc_pkg::SM_CMD: begin
							smbDatOe <= 1'b1;
							ptr <= shiftIn;
						end
						rtc_pkg::SM_WDATA: begin
							smbDatOe <= 1'b1;
							smbWr <= 1'b1;
							smbWdata <= shiftIn;
						end
						default: begin
							smbDatOe <= 1'b0;
						end
					endcase
				end else if (bitCnt == 4'h9) begin
					bitCnt <= 4'h0;
					smbDatOe <= 1'b0;
					case (state)
						rtc_pkg::SM_ADDR: begin
							if (rw) begin
								state <= rtc_pkg::SM_RDATA;
								rdShift <= {rdByte[6:0], 1'b0};
								smbDatOe <= ~rdByte[7];
								rdLoad <= 1'b1;
							end else begin
								state <= rtc_pkg::SM_CMD;
							end
						end
						rtc_pkg::SM_CMD: begin
							state <= rtc_pkg::SM_WDATA;
						end
						rtc_pkg::SM_RDATA: begin
							if (mAck) begin
								rdShift <= {rdByte[6:0], 1'b0};
								smbDatOe <= ~rdByte[7];
								rdLoad <= 1'b1;
							end else begin
								state <= rtc_pkg::SM_IGNORE;
							end
						end
						default: begin
							state <= rtc_pkg::SM_IGNORE;
						end
					endcase
				end else if (state == rtc_pkg::SM_RDATA) begin
					smbDatOe <= ~rdShift[7];
					rdShift <= {rdShift[6:0], 1'b0};
				end
			end
		end
	end

	// A two-wire write wins the cycle; the Wishbone answer waits one clock instead.
	assign adrIdx = (adr_i[31:10] == 22'h000000 && adr_i[1:0] == 2'h0) ? adr_i[9:2]
		: `RTC_IDX_NONE;
	assign wbTake = cyc_i & stb_i & ~ack_o & ~smbWr;
	assign wrEn = smbWr | (wbTake & we_i & sel_i[0]);
	assign wrIdx = smbWr ? ptr : adrIdx;
	assign wrData = smbWr ? smbWdata : dat_i[7:0];
	assign statRd = (rdLoad && ptr == `RTC_IDX_STATUS)
		|| (wbTake && !we_i && adrIdx == `RTC_IDX_STATUS);

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= wbTake;
			if (wbTake) begin
				dat_o <= {24'h000000, regRead(adrIdx)};
			end
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cfg <= `RTC_RST_CONFIG;
			enh <= `RTC_RST_ENH;
			lhs <= `RTC_RST_LHS;
			rhsMsb <= `RTC_RST_RHS_MSB;
			rhsLsb <= 3'h0;
			critSp <= CRIT_SP_RST;
			critHyst <= `RTC_RST_CRIT_HYST;
		end else if (wrEn) begin
			case (wrIdx)
				`RTC_IDX_CONFIG: cfg <= wrData;
				`RTC_IDX_ENH_CFG: enh <= wrData;
				`RTC_IDX_LHS: lhs <= wrData;
				`RTC_IDX_RHS_MSB: rhsMsb <= wrData;
				`RTC_IDX_RHS_LSB: rhsLsb <= wrData[7:5];
				`RTC_IDX_CRIT_SP: begin
					if (cfg[`RTC_CFG_CRIT_UNLOCK]) begin
						critSp <= wrData;
					end
				end
				`RTC_IDX_CRIT_HYST: critHyst <= wrData;
				default: begin
				end
			endcase
		end
	end

	assign rhighHit = tf.unsigned_format_sel ? (tf.word[15:5] > {rhsMsb, rhsLsb})
		: ($signed(tf.word[15:5]) > $signed({rhsMsb, rhsLsb}));

	// A new limit event on the same cycle as a status read is kept, not lost.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			convD <= 1'b0;
			localT <= 8'h00;
			lhigh <= 1'b0;
			rhigh <= 1'b0;
		end else begin
			convD <= convDone;
			if (convDone) begin
				localT <= localRaw;
			end
			if (convDone && $signed(localRaw) > $signed(lhs)) begin
				lhigh <= 1'b1;
			end else if (statRd) begin
				lhigh <= 1'b0;
			end
			if (convD && rhighHit) begin
				rhigh <= 1'b1;
			end else if (statRd) begin
				rhigh <= 1'b0;
			end
		end
	end

	assign critOutN = 1'b0;
	assign critOutNOe = tf.critFlag;
	assign alertOutN = 1'b0;
	assign alertOutNOe = ~cfg[`RTC_CFG_ALERT_MASK] & (lhigh | rhigh | tf.critFlag);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstN);

	a_crit_pin_drive: assert property (tf.critFlag |-> critOutNOe && !critOutN)
		else $error("Critical pin not driven low with flag set.");
	a_crit_locked: assert property (
		wrEn && wrIdx == `RTC_IDX_CRIT_SP && !cfg[`RTC_CFG_CRIT_UNLOCK] |=> $stable(critSp))
		else $error("Locked critical setpoint changed.");
	a_fault_quiet: assert property (
		tf.faultFlag && !lhigh && !rhigh && !tf.critFlag |-> !alertOutNOe && !critOutNOe)
		else $error("Diode fault flag alone drove an output.");
	a_alert_unmasked: assert property (
		!cfg[`RTC_CFG_ALERT_MASK] && (lhigh || rhigh) |-> alertOutNOe)
		else $error("Unmasked status bit did not pull alert low.");
	a_addr_nack: assert property (
		state == rtc_pkg::SM_ADDR && sclFall && bitCnt == 4'h8 && !startC && !stopC
		&& !timedOut && shiftIn[7:1] != `RTC_SLAVE_ADDR
		|=> !smbDatOe && state == rtc_pkg::SM_IGNORE)
		else $error("Foreign address acknowledged.");
	a_read_msb_first: assert property (
		state == rtc_pkg::SM_RDATA && sclFall && bitCnt == 4'h9 && mAck && !startC
		&& !stopC && !timedOut |=> smbDatOe == ~$past(rdMsb))
		else $error("Read byte did not start with its msb.");
	a_bus_timeout: assert property (timedOut |=> state == rtc_pkg::SM_IDLE && !smbDatOe)
		else $error("Bus engine not idle after timeout.");
	a_ptr_latch: assert property (
		state == rtc_pkg::SM_CMD && sclFall && bitCnt == 4'h8 && !startC && !stopC
		&& !timedOut |=> ptr == $past(shiftIn) ##1 state == rtc_pkg::SM_CMD)
		else $error("Command byte not latched as pointer.");

	c_bus_write: cover property (smbWr);
	c_bus_read: cover property (rdLoad ##[1:400] rdLoad);
	c_crit_rise: cover property ($rose(tf.critFlag));
	c_wb_access: cover property (wbTake ##1 ack_o);
	c_bus_timeout: cover property (timedOut);
endmodule

// ===== rtc_smb_host.sv
`timescale 1ns/1ns
module rtc_smb_host (
	// Clock
	input wire logic clk,
	// Bus lines
	input wire logic sdaIn,
	output logic sclOut,
	output logic sdaOe
);
	initial begin
		sclOut = 1'b1;
		sdaOe = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start();
		sdaOe <= 1'b1;
		hold(10);
		sclOut <= 1'b0;
		hold(10);
	endtask
	task automatic stop();
		sclOut <= 1'b0;
		hold(2);
		sdaOe <= 1'b1;
		hold(8);
		sclOut <= 1'b1;
		hold(10);
		sdaOe <= 1'b0;
		hold(10);
	endtask
	// Clock held low long enough to force the slave's timeout.
	task automatic stall(input int n);
		sclOut <= 1'b0;
		hold(n);
	endtask
	// Host owns the clock.
	// Data moves two cycles after the fall so it never looks like a start or stop.
	task automatic bit_slot(input logic b, output logic s);
		sclOut <= 1'b0;
		hold(2);
		sdaOe <= ~b;
		hold(8);
		sclOut <= 1'b1;
		hold(10);
		s = sdaIn;
	endtask
	task automatic send_byte(input logic [7:0] d, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(d[i], s);
		end
		bit_slot(1'b1, nack);
	endtask
	// Acknowledge, or no-acknowledge on the last.
	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, s);
			d[i] = s;
		end
		bit_slot(last, s);
	endtask
	task automatic write_reg(input logic [7:0] a, c, d, output logic [2:0] nk);
		start();
		send_byte(a, nk[2]);
		send_byte(c, nk[1]);
		send_byte(d, nk[0]);
		stop();
	endtask
	task automatic read_reg(input logic [7:0] a, output logic nk, output logic [7:0] d0, d1);
		start();
		send_byte(a, nk);
		recv_byte(1'b0, d0);
		recv_byte(1'b1, d1);
		stop();
	endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ns
module tb;
	logic clk, reset_n, cyc, stb, we, convDone, diodeGnd, diodeOpen;
	logic [31:0] adr, wdat, dat, rd;
	logic [13:0] raw;
	logic ack, datOut, datOe, critN, critOe, alertN, alertOe, scl, hostOe, nk;
	logic [2:0] nks;
	logic [7:0] b0, b1, loc;
	int error_cnt, check_count;
	wire logic sda = ~(hostOe | datOe);
	rtc_sensor_top #(.TIMEOUT_CYC(200)) DUT (.clk(clk), .reset_n(reset_n), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(dat),
		.ack_o(ack), .smbClk(scl), .smbDatIn(sda), .smbDatOut(datOut), .smbDatOe(datOe),
		.remoteRaw(raw), .localRaw(loc), .convDone(convDone), .diodeShortGnd(diodeGnd),
		.diodeOpen(diodeOpen), .critOutNIn(~critOe), .critOutN(critN),
		.critOutNOe(critOe), .alertOutNIn(~alertOe), .alertOutN(alertN),
		.alertOutNOe(alertOe));
	rtc_smb_host host (.clk(clk), .sdaIn(sda), .sclOut(scl), .sdaOe(hostOe));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wb(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		chk("wb ack", 1, ack);
		rd = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [31:0] a, exp, input string name);
		wb(1'b0, a, 0);
		chk(name, exp, rd);
	endtask
	task automatic conv(input logic [13:0] r, input logic g, o);
		diodeGnd <= g;
		diodeOpen <= o;
		raw <= r;
		repeat (4) @(posedge clk);
		convDone <= 1'b1;
		@(posedge clk);
		convDone <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
	initial begin
		{reset_n, cyc, stb, we, convDone, diodeGnd, diodeOpen} = '0;
		{adr, wdat, raw, loc} = '0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		// This block has no fan control, so no setup sequence precedes the reads.
		rdchk(32'h0c, 0, "config");
		rdchk(32'h64, 32'h6e, "crit sp");
		rdchk(32'h84, 32'h0a, "hyst");
		rdchk(32'h400, 0, "unmapped");
		wb(1'b1, 32'h64, 32'h64);
		rdchk(32'h64, 32'h6e, "locked sp");
		wb(1'b1, 32'h0c, 32'h02);
		wb(1'b1, 32'h64, 32'h64);
		rdchk(32'h64, 32'h64, "open sp");
		$display("lock test done");
		conv(14'h0c9f, 0, 0);
		chk("crit frac", 0, critOe);
		conv(14'h0ca0, 0, 0);
		chk("crit set", 1, critOe);
		chk("pin levels", 0, {critN, alertN, datOut});
		chk("alert", 1, alertOe);
		rdchk(32'h08, 32'h12, "status");
		conv(14'h0b60, 0, 0);
		chk("crit hold", 1, critOe);
		conv(14'h0b40, 0, 0);
		chk("crit clear", 0, critOe);
		$display("hysteresis test done");
		wb(1'b1, 32'h1c, 32'h7f);
		wb(1'b1, 32'h64, 32'h7f);
		wb(1'b0, 32'h08, 0);
		conv(14'h0000, 0, 1);
		rdchk(32'h04, 32'h7f, "open msb");
		rdchk(32'h40, 32'h00, "open lsb");
		chk("fault crit", 0, critOe);
		chk("fault alert", 0, alertOe);
		rdchk(32'h08, 32'h04, "fault st");
		wb(1'b1, 32'h64, 32'h64);
		conv(14'h0000, 0, 1);
		chk("fault crit", 1, critOe);
		conv(14'h0000, 1, 1);
		rdchk(32'h04, 32'h80, "gnd msb");
		chk("gnd crit", 0, critOe);
		wb(1'b1, 32'h114, 32'h08);
		conv(14'h0000, 1, 0);
		rdchk(32'h04, 32'h00, "gnd u msb");
		conv(14'h0000, 0, 1);
		rdchk(32'h04, 32'hff, "open u msb");
		chk("u crit", 1, critOe);
		wb(1'b1, 32'h64, 32'hc8);
		conv(14'h12c0, 0, 0);
		chk("u sp", 0, critOe);
		conv(14'h3fe0, 0, 0);
		rdchk(32'h04, 32'h00, "u clamp");
		wb(1'b1, 32'h114, 32'h00);
		conv(14'h0325, 0, 0);
		rdchk(32'h04, 32'h19, "fmt msb");
		rdchk(32'h40, 32'h20, "fmt lsb");
		wb(1'b1, 32'h114, 32'h01);
		loc <= 8'h50;
		conv(14'h0325, 0, 0);
		rdchk(32'h40, 32'h28, "filt lsb");
		rdchk(32'h00, 32'h50, "local");
		rdchk(32'h08, 32'h52, "local high");
		$display("format test done");
		host.write_reg(8'h98, 8'h03, 8'h82, nks);
		chk("bus wr ack", 0, nks);
		rdchk(32'h0c, 32'h82, "bus config");
		chk("alert masked", 0, alertOe);
		host.read_reg(8'h99, nk, b0, b1);
		chk("bus rd ack", 0, nk);
		chk("bus rd0", 32'h82, b0);
		chk("bus rd1", 32'h82, b1);
		host.read_reg(8'h9a, nk, b0, b1);
		chk("bad addr", 1, nk);
		chk("bad data", 32'hff, b0);
		$display("bus test done");
		host.start();
		host.send_byte(8'h98, nk);
		chk("stall addr", 0, nk);
		host.stall(250);
		host.send_byte(8'h03, nk);
		chk("stall cmd", 1, nk);
		host.stop();
		$display("timeout test done");
		stop_test();
	end
endmodule
